// ===== src/tmb_timer.v
// Operation
// R1: Pin clock selected: counter steps on every rising edge of input pin 0.
// R2: Live count is read by software capture into capture register 0.
// R3: Software keeps the prescaler running when counting events.
// R4: Pulse mode toggles output flip-flop on compare 0 or 1 match; drives pin.
// R5: Software keeps compare register 0 below compare register 1.
// R6: With double buffer on, buffered value enters compare 0 at match 1.
// R7: Pulse polarity selectable; frequency and duty from the two compares. Counter here never clears on a match, so period is the 16-bit wrap.
// R8: Flip-flop control write enables match toggles and can force flip-flop low.
// R9: Both trigger enables set makes both matches toggle the flip-flop.
// R10: Optional toggle when counter is loaded into capture register 0.
// R11: Capture mode 11: aux flip-flop rise to capture 0, fall to capture 1.
// R12: Frequency measurement: pin 0 clocks counter, aux edges capture.
// R13: Width capture: pin 0 rise to capture 0, fall to capture 1.
// R14: Interrupt A on pin 0 fall in capture mode 10, else rising edge.
// R15: Time difference: pin 0 rise captures into register 0, raises interrupt A.
// R16: Time difference: pin 1 rise captures into register 1, raises interrupt B.
// R17: Compare 1 match raises its interrupt, same moment as buffer update.
// R18: Run bit low stops and clears counter; high lets it count.
// R19: Every write of 0 to software capture bit captures the counter.
// R20: Software uses no read-modify-write on write-only compare registers.
// R21: Free-running counter wraps from all ones to zero and keeps going.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tmb_defs.vh"

module tmb_timer (
    input wire sys_clk,
    input wire rst,
    input wire [`TMB_ADDR_W-1:0] reg_addr,
    input wire [`TMB_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`TMB_DATA_W-1:0] reg_rdata,
    input wire capture_in0_pin,
    input wire capture_in1_pin,
    input wire aux_timer_flipflop,
    output reg pulse_out_pin,
    output reg ext_int_a,
    output reg ext_int_b,
    output reg compare0_irq,
    output reg compare1_irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg run_control_reg;
    reg prescaler_run_bit_reg;
    reg double_buffer_enable_reg;
    reg [1:0] clk_sel_reg;
    reg [1:0] capture_mode_field_reg;
    reg swcap_bit_reg;
    reg [5:0] flipflop_control_reg;
    reg [`TMB_DATA_W-1:0] compare_reg0;
    reg [`TMB_DATA_W-1:0] compare_buf0_reg;
    reg [`TMB_DATA_W-1:0] compare_reg1;
    reg [`TMB_DATA_W-1:0] capture_reg0;
    reg [`TMB_DATA_W-1:0] capture_reg1;
    reg [`TMB_DATA_W-1:0] up_counter_reg;
    reg [`TMB_PRE_W-1:0] pre_cnt_reg;
    reg output_flipflop_reg;
    reg [`TMB_DATA_W-1:0] rdata_next;
    reg tick;
    reg cap0_ev;
    reg cap1_ev;
    reg int_a_ev;
    wire in0_rise;
    wire in0_fall;
    wire in1_rise;
    wire in1_fall;
    wire aux_rise;
    wire aux_fall;
    wire wr_run;
    wire wr_mode;
    wire wr_ffcr;
    wire wr_cmp0;
    wire wr_cmp1;
    wire [`TMB_DATA_W-1:0] cnt_inc;
    wire match0;
    wire match1;
    wire sw_capture;
    wire [1:0] ff_cmd;
    wire ff_toggle;

    // ----------------------------------------------------------------
    // Edge detectors for pins and aux flip-flop
    // ----------------------------------------------------------------
    tmb_edge u_edge_in0 (
        .sys_clk(sys_clk),
        .rst(rst),
        .sig_in(capture_in0_pin),
        .rise(in0_rise),
        .fall(in0_fall)
    );

    tmb_edge u_edge_in1 (
        .sys_clk(sys_clk),
        .rst(rst),
        .sig_in(capture_in1_pin),
        .rise(in1_rise),
        .fall(in1_fall)
    );

    tmb_edge u_edge_aux (
        .sys_clk(sys_clk),
        .rst(rst),
        .sig_in(aux_timer_flipflop),
        .rise(aux_rise),
        .fall(aux_fall)
    );

    // ----------------------------------------------------------------
    // Register write decode
    // ----------------------------------------------------------------
    assign wr_run = reg_wr && (reg_addr == `TMB_ADDR_RUN);
    assign wr_mode = reg_wr && (reg_addr == `TMB_ADDR_MODE);
    assign wr_ffcr = reg_wr && (reg_addr == `TMB_ADDR_FFCR);
    assign wr_cmp0 = reg_wr && (reg_addr == `TMB_ADDR_CMP0);
    assign wr_cmp1 = reg_wr && (reg_addr == `TMB_ADDR_CMP1);
    // Any mode write with the bit at 0 captures, not only a 1-to-0 change
    assign sw_capture = wr_mode && !reg_wdata[`TMB_MODE_SWCAP]; // [R19] [R2]
    assign ff_cmd = reg_wdata[`TMB_FF_CMD_HI:`TMB_FF_CMD_LO];

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            run_control_reg <= 1'b0;
            prescaler_run_bit_reg <= 1'b0;
            double_buffer_enable_reg <= 1'b0;
            clk_sel_reg <= `TMB_CLK_PIN;
            capture_mode_field_reg <= `TMB_CAP_OFF;
            swcap_bit_reg <= 1'b1;
            flipflop_control_reg <= `TMB_FFCR_RST;
        end else begin
            if (wr_run) begin
                run_control_reg <= reg_wdata[`TMB_RUN_CNT];
                prescaler_run_bit_reg <= reg_wdata[`TMB_RUN_PRE];
                double_buffer_enable_reg <= reg_wdata[`TMB_RUN_DBUF];
            end
            if (wr_mode) begin
                clk_sel_reg <= reg_wdata[`TMB_MODE_CLK_HI:`TMB_MODE_CLK_LO];
                capture_mode_field_reg <= reg_wdata[`TMB_MODE_CAP_HI:`TMB_MODE_CAP_LO];
                swcap_bit_reg <= reg_wdata[`TMB_MODE_SWCAP];
            end
            // Command field is a one-shot action and always reads back as keep
            if (wr_ffcr) begin
                flipflop_control_reg <= {reg_wdata[`TMB_FF_POL:`TMB_FF_E0T1],
                    `TMB_FF_CMD_KEEP}; // [R8] [R9]
            end
        end
    end

    // ----------------------------------------------------------------
    // Shared prescaler and count tick
    // ----------------------------------------------------------------
    // Prescaler stops and clears when its run bit is low
    always @(posedge sys_clk) begin
        if (rst) begin
            pre_cnt_reg <= {`TMB_PRE_W{1'b0}};
        end else if (!prescaler_run_bit_reg) begin
            pre_cnt_reg <= {`TMB_PRE_W{1'b0}};
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 1'b1;
        end
    end

    // Pin clock counts edges only; prescaler taps need the prescaler running
    always @* begin
        case (clk_sel_reg)
            `TMB_CLK_PIN: tick = in0_rise; // [R1] [R12]
            `TMB_CLK_DIV2: tick = prescaler_run_bit_reg &&
                ((pre_cnt_reg & `TMB_PRE_MASK2) == `TMB_PRE_MASK2);
            `TMB_CLK_DIV8: tick = prescaler_run_bit_reg &&
                ((pre_cnt_reg & `TMB_PRE_MASK8) == `TMB_PRE_MASK8);
            `TMB_CLK_DIV32: tick = prescaler_run_bit_reg &&
                ((pre_cnt_reg & `TMB_PRE_MASK32) == `TMB_PRE_MASK32);
            default: tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Up counter
    // ----------------------------------------------------------------
    assign cnt_inc = up_counter_reg + `TMB_ONE16;
    // Match fires on the step that lands on the compare value
    assign match0 = run_control_reg && tick && (cnt_inc == compare_reg0); // [R4]
    assign match1 = run_control_reg && tick && (cnt_inc == compare_reg1); // [R4]

    // Wraps naturally at all ones; no clear on match in this block
    always @(posedge sys_clk) begin
        if (rst) begin
            up_counter_reg <= `TMB_ZERO16;
        end else if (!run_control_reg) begin
            up_counter_reg <= `TMB_ZERO16; // [R18]
        end else if (tick) begin
            up_counter_reg <= cnt_inc; // [R18] [R21]
        end
    end

    // ----------------------------------------------------------------
    // Compare registers and double buffer
    // ----------------------------------------------------------------
    // With double buffer on, buffered value waits for the compare 1 match to enter compare 0
    always @(posedge sys_clk) begin
        if (rst) begin
            compare_reg0 <= `TMB_ZERO16;
            compare_buf0_reg <= `TMB_ZERO16;
            compare_reg1 <= `TMB_ZERO16;
        end else begin
            if (wr_cmp0) begin
                compare_buf0_reg <= reg_wdata;
            end
            if (wr_cmp0 && !double_buffer_enable_reg) begin
                compare_reg0 <= reg_wdata;
            end else if (double_buffer_enable_reg && match1) begin
                compare_reg0 <= compare_buf0_reg; // [R6] [R17]
            end
            if (wr_cmp1) begin
                compare_reg1 <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Capture trigger select
    // ----------------------------------------------------------------
    always @* begin
        cap0_ev = sw_capture; // [R2]
        cap1_ev = 1'b0;
        int_a_ev = in0_rise; // [R14] [R15]
        case (capture_mode_field_reg)
            `TMB_CAP_OFF: begin
                cap0_ev = sw_capture;
            end
            `TMB_CAP_TWO_PIN: begin
                cap0_ev = sw_capture | in0_rise; // [R15]
                cap1_ev = in1_rise; // [R16]
            end
            `TMB_CAP_WIDTH: begin
                cap0_ev = sw_capture | in0_rise; // [R13]
                cap1_ev = in0_fall; // [R13]
                int_a_ev = in0_fall; // [R14]
            end
            `TMB_CAP_AUX: begin
                cap0_ev = sw_capture | aux_rise; // [R11] [R12]
                cap1_ev = aux_fall; // [R11] [R12]
            end
            default: begin
                cap1_ev = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Capture registers
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            capture_reg0 <= `TMB_ZERO16;
            capture_reg1 <= `TMB_ZERO16;
        end else begin
            if (cap0_ev) begin
                capture_reg0 <= up_counter_reg; // [R2] [R19]
            end
            if (cap1_ev) begin
                capture_reg1 <= up_counter_reg; // [R16]
            end
        end
    end

    // ----------------------------------------------------------------
    // Output flip-flop
    // ----------------------------------------------------------------
    // Both matches in one cycle cannot occur when compare 0 < compare 1
    assign ff_toggle =
        (match0 && flipflop_control_reg[`TMB_FF_E0T1]) ^ // [R9] [R4]
        (match1 && flipflop_control_reg[`TMB_FF_E1T1]) ^ // [R9] [R4]
        (cap0_ev && flipflop_control_reg[`TMB_FF_C0T1]); // [R10]

    // A clear, set or invert command in the same cycle wins over a hardware toggle
    always @(posedge sys_clk) begin
        if (rst) begin
            output_flipflop_reg <= 1'b0;
        end else if (wr_ffcr && ff_cmd == `TMB_FF_CMD_CLR) begin
            output_flipflop_reg <= 1'b0; // [R8]
        end else if (wr_ffcr && ff_cmd == `TMB_FF_CMD_SET) begin
            output_flipflop_reg <= 1'b1;
        end else if (wr_ffcr && ff_cmd == `TMB_FF_CMD_INV) begin
            output_flipflop_reg <= ~output_flipflop_reg;
        end else if (ff_toggle) begin
            output_flipflop_reg <= ~output_flipflop_reg; // [R4]
        end
    end

    // ----------------------------------------------------------------
    // Pin and event outputs
    // ----------------------------------------------------------------
    // Events are registered so every output comes from a flip-flop
    always @(posedge sys_clk) begin
        if (rst) begin
            pulse_out_pin <= 1'b0;
            ext_int_a <= 1'b0;
            ext_int_b <= 1'b0;
            compare0_irq <= 1'b0;
            compare1_irq <= 1'b0;
        end else begin
            pulse_out_pin <= output_flipflop_reg ^
                flipflop_control_reg[`TMB_FF_POL]; // [R4] [R7]
            ext_int_a <= int_a_ev; // [R14] [R15]
            ext_int_b <= in1_rise; // [R16]
            compare0_irq <= match0;
            compare1_irq <= match1; // [R17]
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Compare registers are write-only and read as zero
    always @* begin
        rdata_next = `TMB_ZERO16;
        case (reg_addr)
            `TMB_ADDR_RUN: begin
                rdata_next[`TMB_RUN_CNT] = run_control_reg;
                rdata_next[`TMB_RUN_PRE] = prescaler_run_bit_reg;
                rdata_next[`TMB_RUN_DBUF] = double_buffer_enable_reg;
            end
            `TMB_ADDR_MODE: begin
                rdata_next[`TMB_MODE_CLK_HI:`TMB_MODE_CLK_LO] = clk_sel_reg;
                rdata_next[`TMB_MODE_CAP_HI:`TMB_MODE_CAP_LO] = capture_mode_field_reg;
                rdata_next[`TMB_MODE_SWCAP] = swcap_bit_reg;
            end
            `TMB_ADDR_FFCR: begin
                rdata_next[`TMB_FF_POL:`TMB_FF_CMD_LO] = flipflop_control_reg;
            end
            `TMB_ADDR_CAP0: begin
                rdata_next = capture_reg0;
            end
            `TMB_ADDR_CAP1: begin
                rdata_next = capture_reg1;
            end
            `TMB_ADDR_STAT: begin
                rdata_next[`TMB_STAT_FF] = output_flipflop_reg;
            end
            default: begin
                rdata_next = `TMB_ZERO16;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= `TMB_ZERO16;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= `TMB_ZERO16;
        end
    end
endmodule

`default_nettype wire

// ===== src/tmb_defs.vh
`ifndef TMB_DEFS_VH
`define TMB_DEFS_VH

// ----------------------------------------------------------------
// Register map (word index on the plain register port)
// ----------------------------------------------------------------
`define TMB_ADDR_W 4
`define TMB_DATA_W 16
`define TMB_ADDR_RUN 4'h0
`define TMB_ADDR_MODE 4'h1
`define TMB_ADDR_FFCR 4'h2
`define TMB_ADDR_CMP0 4'h4
`define TMB_ADDR_CMP1 4'h5
`define TMB_ADDR_CAP0 4'h6
`define TMB_ADDR_CAP1 4'h7
`define TMB_ADDR_STAT 4'h8
`define TMB_STAT_FF 0

// ----------------------------------------------------------------
// Run register fields
// ----------------------------------------------------------------
`define TMB_RUN_CNT 0
`define TMB_RUN_PRE 2
`define TMB_RUN_DBUF 7

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define TMB_MODE_CLK_LO 0
`define TMB_MODE_CLK_HI 1
`define TMB_MODE_CAP_LO 3
`define TMB_MODE_CAP_HI 4
`define TMB_MODE_SWCAP 5

// Clock source codes
`define TMB_CLK_PIN 2'h0
`define TMB_CLK_DIV2 2'h1
`define TMB_CLK_DIV8 2'h2
`define TMB_CLK_DIV32 2'h3

// Capture mode codes
`define TMB_CAP_OFF 2'h0
`define TMB_CAP_TWO_PIN 2'h1
`define TMB_CAP_WIDTH 2'h2
`define TMB_CAP_AUX 2'h3

// ----------------------------------------------------------------
// Flip-flop control fields
// ----------------------------------------------------------------
`define TMB_FF_CMD_LO 0
`define TMB_FF_CMD_HI 1
`define TMB_FF_E0T1 2
`define TMB_FF_E1T1 3
`define TMB_FF_C0T1 4
`define TMB_FF_POL 5
`define TMB_FF_CMD_INV 2'h0
`define TMB_FF_CMD_SET 2'h1
`define TMB_FF_CMD_CLR 2'h2
`define TMB_FF_CMD_KEEP 2'h3
`define TMB_FFCR_RST 6'h03

// ----------------------------------------------------------------
// Prescaler taps and reset values
// ----------------------------------------------------------------
`define TMB_PRE_W 5
`define TMB_PRE_MASK2 5'h01
`define TMB_PRE_MASK8 5'h07
`define TMB_PRE_MASK32 5'h1f
`define TMB_ZERO16 16'h0000
`define TMB_ONE16 16'h0001

`endif

// ===== src/tmb_edge.v
`timescale 1ns/10ps
`default_nettype none

module tmb_edge (
    input wire sys_clk,
    input wire rst,
    input wire sig_in,
    output wire rise,
    output wire fall
);
    reg prev_reg;

    // ----------------------------------------------------------------
    // Edge detect
    // ----------------------------------------------------------------
    // Inputs are synchronous already, so one stage suffices
    always @(posedge sys_clk) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sig_in;
        end
    end

    assign rise = sig_in & ~prev_reg;
    assign fall = ~sig_in & prev_reg;
endmodule

`default_nettype wire

// ===== testbench/tmb_timer_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmb_defs.vh"

module tmb_timer_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [`TMB_ADDR_W-1:0] reg_addr,
    input wire logic [`TMB_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`TMB_DATA_W-1:0] reg_rdata,
    input wire logic capture_in0_pin,
    input wire logic capture_in1_pin,
    input wire logic aux_timer_flipflop,
    input wire logic pulse_out_pin,
    input wire logic ext_int_a,
    input wire logic ext_int_b,
    input wire logic compare0_irq,
    input wire logic compare1_irq
);
    logic [1:0] cap_mode_reg;
    logic run_reg;
    logic tog_en_reg;
    wire ffcr_wr = reg_wr && (reg_addr == `TMB_ADDR_FFCR);
    wire set_bit = reg_wdata[0];
    wire pol_bit = reg_wdata[5];

    // Shadow copies, so checks know the live mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cap_mode_reg <= 2'h0;
            run_reg <= 1'b0;
            tog_en_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `TMB_ADDR_MODE)
                cap_mode_reg <= reg_wdata[4:3];
            if (reg_wr && reg_addr == `TMB_ADDR_RUN)
                run_reg <= reg_wdata[0];
            if (ffcr_wr)
                tog_en_reg <= |reg_wdata[4:2];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Force command: set or clear, then output register
    sequence ffcr_force_s;
        ffcr_wr && (reg_wdata[1] != reg_wdata[0]);
    endsequence

    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data seen without a read");
    cmp_read_a: assert property ($past(reg_rd) && ($past(reg_addr) == `TMB_ADDR_CMP0
        || $past(reg_addr) == `TMB_ADDR_CMP1) |-> reg_rdata == 16'h0000)
        else $error("compare register read back nonzero");
    int_a_rise_a: assert property ($rose(capture_in0_pin)
        && cap_mode_reg != `TMB_CAP_WIDTH |-> ##[1:3] ext_int_a)
        else $error("interrupt A missing after pin 0 rise");
    int_a_fall_a: assert property ($fell(capture_in0_pin)
        && cap_mode_reg == `TMB_CAP_WIDTH |-> ##[1:3] ext_int_a)
        else $error("interrupt A missing after pin 0 fall");
    int_a_quiet_a: assert property ($rose(capture_in0_pin)
        && cap_mode_reg == `TMB_CAP_WIDTH |-> ##1 (!ext_int_a) [*3])
        else $error("interrupt A on rise in width mode");
    int_b_rise_a: assert property ($rose(capture_in1_pin) |-> ##[1:3] ext_int_b)
        else $error("interrupt B missing after pin 1 rise");
    irq_single_a: assert property (compare1_irq || ext_int_b
        |=> !compare1_irq && !ext_int_b)
        else $error("interrupt pulse longer than one cycle");
    ff_force_a: assert property (ffcr_force_s |-> ##2
        pulse_out_pin == ($past(set_bit, 2) ^ $past(pol_bit, 2)))
        else $error("forced flip-flop level not on pulse pin");
    ff_hold_a: assert property (!tog_en_reg && !$past(ffcr_wr) && !$past(ffcr_wr, 2)
        && !$past(ffcr_wr, 3) |-> $stable(pulse_out_pin))
        else $error("pulse pin moved with toggles disabled");
    run_stop_a: assert property (!run_reg && !$past(run_reg) && !$past(run_reg, 2)
        |-> !compare0_irq && !compare1_irq)
        else $error("match interrupt while counter stopped");
endmodule

bind tmb_timer tmb_timer_checker chk_i (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .capture_in0_pin(capture_in0_pin), .capture_in1_pin(capture_in1_pin),
    .aux_timer_flipflop(aux_timer_flipflop), .pulse_out_pin(pulse_out_pin),
    .ext_int_a(ext_int_a), .ext_int_b(ext_int_b),
    .compare0_irq(compare0_irq), .compare1_irq(compare1_irq)
);
`default_nettype wire

// ===== testbench/tmb_pulse_env.sv
`timescale 1ns/10ps
`default_nettype none

module tmb_pulse_env (
    input wire logic sys_clk,
    input wire logic pulse_out_pin,
    output logic in0_pin,
    output logic in1_pin,
    output logic aux_ff
);
    // Sources start low; the load only watches pulse_out_pin
    initial begin
        in0_pin = 1'b0;
        in1_pin = 1'b0;
        aux_ff = 1'b0;
    end

    // Levels move just after an edge, never on it
    task automatic drive(input logic [2:0] v);
        @(posedge sys_clk);
        {aux_ff, in1_pin, in0_pin} <= v;
    endtask

    // Event pulse on pin 0, wide enough for the edge detector
    task automatic pulse0(input int n_hi, input int n_lo);
        @(posedge sys_clk);
        in0_pin <= 1'b1;
        repeat (n_hi) @(posedge sys_clk);
        in0_pin <= 1'b0;
        repeat (n_lo) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb_tmb_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmb_defs.vh"

module tb_tmb_timer;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic in0, in1, aux, pulse_out, int_a, int_b, irq0, irq1;
    logic [15:0] c0, c1, d;
    logic [1:0] g;
    int n_fail = 0;
    int checks_done = 0;
    int na = 0;
    int nb = 0;
    int ka, kb, i;

    tmb_timer uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .capture_in0_pin(in0), .capture_in1_pin(in1), .aux_timer_flipflop(aux),
        .pulse_out_pin(pulse_out), .ext_int_a(int_a), .ext_int_b(int_b),
        .compare0_irq(irq0), .compare1_irq(irq1));
    tmb_pulse_env env (.sys_clk(sys_clk), .pulse_out_pin(pulse_out),
        .in0_pin(in0), .in1_pin(in1), .aux_ff(aux));

    // 100 ns clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // Interrupt pulse counters
    always @(posedge sys_clk) begin
        if (int_a === 1'b1) na <= na + 1;
        if (int_b === 1'b1) nb <= nb + 1;
    end

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Bounded wait for the first match interrupt, {irq1, irq0}
    task automatic wait_irq(output logic [1:0] got);
        got = 2'b00;
        for (i = 0; i < 90 && got === 2'b00; i++) begin
            @(posedge sys_clk);
            #1 got = {irq1, irq0};
        end
        if (got === 2'b00) begin
            n_fail++;
            $display("unexpected match irq: expected nonzero seen %b", got);
            end_of_test();
        end
    endtask

    task automatic pin_after(input int n, input logic e);
        repeat (n) @(posedge sys_clk);
        #1 chk("pulse_out", {15'h0000, e}, {15'h0000, pulse_out});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset values and unmapped place
        rd(`TMB_ADDR_RUN, d); chk("run", 16'h0000, d);
        rd(`TMB_ADDR_MODE, d); chk("mode", 16'h0020, d);
        rd(`TMB_ADDR_FFCR, d); chk("ffcr", 16'h0003, d);
        rd(`TMB_ADDR_CMP1, d); chk("cmp1", 16'h0000, d);
        rd(4'hf, d); chk("unmapped", 16'h0000, d);
        $display("test reset done");
        // Event counting on pin 0, read by soft capture
        wr(`TMB_ADDR_RUN, 16'h0005);
        repeat (5) env.pulse0(2, 2);
        wr(`TMB_ADDR_MODE, 16'h0000);
        rd(`TMB_ADDR_CAP0, d); chk("event count", 16'h0005, d);
        repeat (2) env.pulse0(2, 2);
        wr(`TMB_ADDR_MODE, 16'h0000);
        rd(`TMB_ADDR_CAP0, d); chk("second capture", 16'h0007, d);
        $display("test event done");
        // Pulse width, sys/2 clock
        wr(`TMB_ADDR_MODE, 16'h0031);
        ka = na;
        env.pulse0(20, 4);
        chk("int a count", 16'h0001, 16'(na - ka));
        rd(`TMB_ADDR_CAP0, c0);
        rd(`TMB_ADDR_CAP1, c1);
        chk("width", 16'h000a, c1 - c0);
        $display("test width done");
        // Time difference between pins 0 and 1
        wr(`TMB_ADDR_MODE, 16'h0029);
        ka = na;
        kb = nb;
        env.drive(3'b001);
        repeat (29) @(posedge sys_clk);
        env.drive(3'b011);
        repeat (5) @(posedge sys_clk);
        env.drive(3'b000);
        repeat (5) @(posedge sys_clk);
        chk("int a count", 16'h0001, 16'(na - ka));
        chk("int b count", 16'h0001, 16'(nb - kb));
        rd(`TMB_ADDR_CAP0, c0);
        rd(`TMB_ADDR_CAP1, c1);
        chk("difference", 16'h000f, c1 - c0);
        $display("test difference done");
        // Frequency: pin 0 counts, aux flip-flop edges capture
        wr(`TMB_ADDR_MODE, 16'h0038);
        ka = na;
        env.drive(3'b100);
        repeat (6) env.pulse0(2, 2);
        env.drive(3'b000);
        repeat (6) @(posedge sys_clk);
        chk("int a count", 16'h0006, 16'(na - ka));
        rd(`TMB_ADDR_CAP0, c0);
        rd(`TMB_ADDR_CAP1, c1);
        chk("frequency", 16'h0006, c1 - c0);
        wr(`TMB_ADDR_RUN, 16'h0004);
        wr(`TMB_ADDR_MODE, 16'h0000);
        rd(`TMB_ADDR_CAP0, d); chk("stopped count", 16'h0000, d);
        $display("test frequency done");
        // Pulse generation with buffered compare 0
        wr(`TMB_ADDR_CMP1, 16'h0007);
        wr(`TMB_ADDR_RUN, 16'h0080);
        wr(`TMB_ADDR_CMP0, 16'h0003);
        wr(`TMB_ADDR_FFCR, 16'h000e);
        wr(`TMB_ADDR_MODE, 16'h0022);
        wr(`TMB_ADDR_RUN, 16'h0085);
        wait_irq(g); chk("first match", 16'h0002, {14'h0000, g});
        wr(`TMB_ADDR_RUN, 16'h0084);
        wr(`TMB_ADDR_FFCR, 16'h000e);
        wr(`TMB_ADDR_RUN, 16'h0085);
        wait_irq(g); chk("buffered match", 16'h0001, {14'h0000, g});
        pin_after(2, 1'b1);
        wait_irq(g); chk("period match", 16'h0002, {14'h0000, g});
        pin_after(2, 1'b0);
        wr(`TMB_ADDR_RUN, 16'h0084);
        wr(`TMB_ADDR_FFCR, 16'h002e);
        pin_after(3, 1'b1);
        wr(`TMB_ADDR_FFCR, 16'h0021); pin_after(3, 1'b0);
        wr(`TMB_ADDR_FFCR, 16'h0020); pin_after(3, 1'b1);
        $display("test pulse done");
        // Toggle on capture load
        wr(`TMB_ADDR_FFCR, 16'h0012);
        pin_after(3, 1'b0);
        wr(`TMB_ADDR_MODE, 16'h0003);
        pin_after(3, 1'b1);
        $display("test capture toggle done");
        end_of_test();
    end
endmodule
`default_nettype wire
